// File: include/bad_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// shared constants for the expansion board bus interface and address decoder
package bad_pkg;

  // backplane widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int OFFS_W = 12;
  localparam int BLOCKS = 16;
  localparam int BANKS = 8;

  // extended address field
  localparam int A_TOP = 19;
  localparam int BANK_LO = 16;
  localparam int BANK_W = 3;

  // memory address fields
  localparam int BLOCK_LO = 12;
  localparam int BLOCK_W = 4;
  localparam int SUB_LO = 10;
  localparam int SUB_W = 2;
  localparam int HALF_BIT = 11;

  // port address fields
  localparam int PBLK_LO = 4;
  localparam int PBLK_W = 4;
  localparam int INH_LO = 2;
  localparam int INH_W = 2;
  localparam logic [INH_W-1:0] INH_CODE = 2'h3;
  localparam int PAIR_LO = 1;
  localparam int PAIR_W = 3;

  // port pair codes inside the selected block
  localparam logic [PAIR_W-1:0] PAIR_SER1 = 3'h0;
  localparam logic [PAIR_W-1:0] PAIR_SER2 = 3'h1;
  localparam logic [PAIR_W-1:0] PAIR_TAPE = 3'h2;
  localparam logic [PAIR_W-1:0] PAIR_PAR_A = 3'h3;
  localparam logic [PAIR_W-1:0] PAIR_PAR_B = 3'h4;
  localparam logic [PAIR_W-1:0] PAIR_SWITCH = 3'h5;

  // per-memory strap: {two_k, sub, block}
  localparam int NUM_MEM = 5;
  localparam int MCFG_W = BLOCK_W + SUB_W + 1;
  localparam int MCFG_SUB_LO = BLOCK_W;
  localparam int MCFG_2K = BLOCK_W + SUB_W;

  // synchronised input vector layout
  localparam int IN_ADDR = 0;
  localparam int IN_SMEMR = IN_ADDR + ADDR_W;
  localparam int IN_SINP = IN_SMEMR + 1;
  localparam int IN_SOUT = IN_SINP + 1;
  localparam int IN_MWRITE = IN_SOUT + 1;
  localparam int IN_JUMP = IN_MWRITE + 1;
  localparam int IN_IDATA = IN_JUMP + 1;
  localparam int IN_DOUT = IN_IDATA + DATA_W;
  localparam int IN_EXTEN = IN_DOUT + DATA_W;
  localparam int IN_A19M = IN_EXTEN + 1;
  localparam int IN_BANK = IN_A19M + 1;
  localparam int IN_PBLK = IN_BANK + BANK_W;
  localparam int IN_MCFG = IN_PBLK + PBLK_W;
  localparam int IN_W = IN_MCFG + NUM_MEM * MCFG_W;

  // registered state of the decoder
  typedef struct packed {
    logic [DATA_W-1:0] din;
    logic din_oe;
    logic out_en_n;
    logic in_en_n;
    logic [DATA_W-1:0] idata;
    logic idata_oe;
    logic board_sel;
    logic io_act;
    logic bank_en_n;
    logic [BLOCKS-1:0] block_n;
    logic [NUM_MEM-1:0] mem_ce_n;
    logic [OFFS_W-1:0] addr_buf;
    logic ser1_n;
    logic ser2_n;
    logic tape_n;
    logic par_n;
    logic sw_n;
    logic func_wr;
  } bad_state_t;

endpackage

// File: hw/bad_sync.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// three-stage pin synchroniser; a change is taken once stages two and three
// agree, so a single sampled glitch never reaches the decoder
module bad_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // pins and filtered levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] held;
  } bad_sync_st_t;

  bad_sync_st_t st_q, st_d;

  ////////////////////////////////////////////////////////////////////////////
  // shift chain; s1 feeds only s2
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.held[i] = st_q.s3[i];  // bits settle independently
      end
    end
    if (!rst_n_i) begin
      st_d = '0;
    end
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    st_q <= st_d;
  end

  assign sync_o = st_q.held;

endmodule // bad_sync

// File: hw/bad_decode.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module bad_decode (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // backplane cycle
  input wire logic [bad_pkg::ADDR_W-1:0] addr_i,
  input wire logic smemr_i,
  input wire logic sinp_i,
  input wire logic sout_i,
  input wire logic mwrite_i,
  input wire logic jump_oe_i,
  // backplane data buses
  input wire logic [bad_pkg::DATA_W-1:0] dout_i,
  output logic [bad_pkg::DATA_W-1:0] din_o,
  output logic din_oe_o,
  // internal tristate data bus
  input wire logic [bad_pkg::DATA_W-1:0] int_data_i,
  output logic [bad_pkg::DATA_W-1:0] int_data_o,
  output logic int_data_oe_o,
  // static straps
  input wire logic ext_addr_en_i,
  input wire logic a19_match_i,
  input wire logic [bad_pkg::BANK_W-1:0] bank_cfg_i,
  input wire logic [bad_pkg::PBLK_W-1:0] port_block_cfg_i,
  input wire logic [bad_pkg::NUM_MEM*bad_pkg::MCFG_W-1:0] mem_cfg_i,
  // buffer and board status
  output logic out_buffer_enable_n_o,
  output logic in_buffer_enable_n_o,
  output logic board_select_o,
  output logic io_cycle_active_o,
  output logic bank_enable_n_o,
  output logic func_write_o,
  // memory selects
  output logic [bad_pkg::BLOCKS-1:0] block_sel_n_o,
  output logic [bad_pkg::NUM_MEM-1:0] mem_ce_n_o,
  output logic [bad_pkg::OFFS_W-1:0] mem_addr_o,
  // port selects
  output logic serial_one_select_n_o,
  output logic serial_two_select_n_o,
  output logic tape_select_n_o,
  output logic parallel_adapter_select_n_o,
  output logic switch_reg_select_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // one memory hit: block match, then 1K quarter or 2K half inside it;
  // a 2K part ignores A10, so only the upper strap bit of sub is compared
  // and the lower one is a don't-care for that socket
  function automatic logic mem_hit(
    input logic [bad_pkg::ADDR_W-1:0] a,
    input logic [bad_pkg::MCFG_W-1:0] cfg
  );
    logic blk_ok;
    logic sub_ok;
    blk_ok = a[bad_pkg::BLOCK_LO +: bad_pkg::BLOCK_W] ==
             cfg[0 +: bad_pkg::BLOCK_W];
    if (cfg[bad_pkg::MCFG_2K]) begin
      sub_ok = a[bad_pkg::HALF_BIT] ==
               cfg[bad_pkg::MCFG_SUB_LO + bad_pkg::SUB_W - 1];
    end else begin
      sub_ok = a[bad_pkg::SUB_LO +: bad_pkg::SUB_W] ==
               cfg[bad_pkg::MCFG_SUB_LO +: bad_pkg::SUB_W];
    end
    return blk_ok && sub_ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; costs four cycles of latency but keeps the
  // decoder free of metastable levels from the backplane
  // straps pass the same chain; being static, the extra delay only
  // matters right after reset, when the first decode waits for them

  logic [bad_pkg::IN_W-1:0] raw_in;
  logic [bad_pkg::IN_W-1:0] syn;

  // pack every pin into one vector
  assign raw_in = {mem_cfg_i, port_block_cfg_i, bank_cfg_i, a19_match_i,
                   ext_addr_en_i, dout_i, int_data_i, jump_oe_i, mwrite_i,
                   sout_i, sinp_i, smemr_i, addr_i};

  bad_sync #(
    .W(bad_pkg::IN_W)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(raw_in),
    .sync_o(syn)
  );

  // unpacked synchronised fields
  // names below are filtered levels, never the raw pins
  logic [bad_pkg::ADDR_W-1:0] a;
  logic smemr;
  logic sinp;
  logic sout;
  logic mwrite;
  logic jump;
  logic [bad_pkg::DATA_W-1:0] idata;
  logic [bad_pkg::DATA_W-1:0] dout;
  logic ext_en;
  logic a19_match;
  logic [bad_pkg::BANK_W-1:0] bank_cfg;
  logic [bad_pkg::PBLK_W-1:0] pblk_cfg;
  logic [bad_pkg::NUM_MEM*bad_pkg::MCFG_W-1:0] mcfg;

  // field split
  assign a = syn[bad_pkg::IN_ADDR +: bad_pkg::ADDR_W];
  assign smemr = syn[bad_pkg::IN_SMEMR];
  assign sinp = syn[bad_pkg::IN_SINP];
  assign sout = syn[bad_pkg::IN_SOUT];
  assign mwrite = syn[bad_pkg::IN_MWRITE];
  assign jump = syn[bad_pkg::IN_JUMP];
  assign idata = syn[bad_pkg::IN_IDATA +: bad_pkg::DATA_W];
  assign dout = syn[bad_pkg::IN_DOUT +: bad_pkg::DATA_W];
  assign ext_en = syn[bad_pkg::IN_EXTEN];
  assign a19_match = syn[bad_pkg::IN_A19M];
  assign bank_cfg = syn[bad_pkg::IN_BANK +: bad_pkg::BANK_W];
  assign pblk_cfg = syn[bad_pkg::IN_PBLK +: bad_pkg::PBLK_W];
  assign mcfg = syn[bad_pkg::IN_MCFG +: bad_pkg::NUM_MEM * bad_pkg::MCFG_W];

  ////////////////////////////////////////////////////////////////////////////
  // decode and registered outputs

  // one packed state holds every registered output
  bad_pkg::bad_state_t st_q, st_d;

  always_comb begin
    logic io_act;
    logic top_ok;
    logic [bad_pkg::BANKS-1:0] bank_dec;
    logic bank_ok;
    logic mem_ok;
    logic [bad_pkg::NUM_MEM-1:0] hit;
    logic port_ok;
    logic [bad_pkg::PAIR_W-1:0] pair;
    logic ports_any;
    logic sel;
    logic rd_en;
    logic wr_en;
    // locals cleared first so no path leaves a latch
    io_act = 1'b0;
    top_ok = 1'b0;
    bank_dec = '0;
    bank_ok = 1'b0;
    mem_ok = 1'b0;
    hit = '0;
    port_ok = 1'b0;
    pair = '0;
    ports_any = 1'b0;
    sel = 1'b0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    st_d = st_q;

    // any io strobe means this is not a memory cycle
    io_act = sinp | sout;

    // top bit polarity strap qualifies the bank decoder
    // a mismatched top bit leaves every bank output idle
    top_ok = a[bad_pkg::A_TOP] == a19_match;
    if (top_ok) begin
      bank_dec[a[bad_pkg::BANK_LO +: bad_pkg::BANK_W]] = 1'b1;
    end
    // bank enable held true while extended addressing is strapped off
    // limitation: only one bank output can be strapped to the enable
    bank_ok = !ext_en || bank_dec[bank_cfg];

    // memory may only answer outside io cycles, inside our bank
    // block selects stay idle in io so a port cycle never opens a memory
    mem_ok = bank_ok && !io_act;
    st_d.block_n = '1;
    if (mem_ok) begin
      st_d.block_n[a[bad_pkg::BLOCK_LO +: bad_pkg::BLOCK_W]] = 1'b0;
    end
    // each socket compares its own strap; overlapping straps are not caught
    for (int m = 0; m < bad_pkg::NUM_MEM; m++) begin
      hit[m] = mem_ok &&
               mem_hit(a, mcfg[m * bad_pkg::MCFG_W +: bad_pkg::MCFG_W]);
    end
    st_d.mem_ce_n = ~hit;
    // low offset follows the pins on every cycle, selected or not
    st_d.addr_buf = a[bad_pkg::OFFS_W-1:0];

    // port block decode, upper quarter of each block inhibited
    port_ok = io_act &&
              a[bad_pkg::PBLK_LO +: bad_pkg::PBLK_W] == pblk_cfg &&
              a[bad_pkg::INH_LO +: bad_pkg::INH_W] != bad_pkg::INH_CODE;
    // pair code drops A0, so each select covers two neighbouring ports; the parallel adapter select takes two pairs, four ports
    pair = a[bad_pkg::PAIR_LO +: bad_pkg::PAIR_W];
    st_d.ser1_n = 1'b1;
    st_d.ser2_n = 1'b1;
    st_d.tape_n = 1'b1;
    st_d.par_n = 1'b1;
    st_d.sw_n = 1'b1;
    if (port_ok) begin
      unique case (pair)
        bad_pkg::PAIR_SER1: st_d.ser1_n = 1'b0;
        bad_pkg::PAIR_SER2: st_d.ser2_n = 1'b0;
        bad_pkg::PAIR_TAPE: st_d.tape_n = 1'b0;
        bad_pkg::PAIR_PAR_A,
        bad_pkg::PAIR_PAR_B: st_d.par_n = 1'b0;
        bad_pkg::PAIR_SWITCH: st_d.sw_n = 1'b0;
        default: ;  // inhibited codes never reach here
      endcase
    end
    ports_any = port_ok;

    // board answers for any memory or port of its own
    // hits count per socket, not per 4K block, so an empty part of a
    // block leaves the board quiet on the backplane
    sel = (|hit) || ports_any;

    // read path toward the backplane; jump request bypasses decode
    // enable and drive share one term so they can never split
    rd_en = (sel && (smemr || sinp)) || jump;
    st_d.out_en_n = !rd_en;
    st_d.din_oe = rd_en;
    st_d.din = rd_en ? idata : '0;

    // write path always opens, but functions only see selected writes
    // trade-off: the internal bus also moves on foreign writes, which
    // costs toggling but keeps the buffer enable free of the decode
    wr_en = mwrite || sout;
    st_d.in_en_n = !wr_en;
    st_d.idata_oe = wr_en;
    st_d.idata = wr_en ? dout : '0;
    st_d.func_wr = wr_en && sel;

    st_d.board_sel = sel;
    st_d.io_act = io_act;
    st_d.bank_en_n = !bank_ok;

    // reset: every select idle, both buffers off
    // zero first, then every active low output back to its idle high
    if (!rst_n_i) begin
      st_d = '0;
      st_d.out_en_n = 1'b1;
      st_d.in_en_n = 1'b1;
      st_d.bank_en_n = 1'b1;
      st_d.block_n = '1;
      st_d.mem_ce_n = '1;
      st_d.ser1_n = 1'b1;
      st_d.ser2_n = 1'b1;
      st_d.tape_n = 1'b1;
      st_d.par_n = 1'b1;
      st_d.sw_n = 1'b1;
    end
  end

  // state register
  // no reset term here; the clear is folded into the next state
  always_ff @(posedge core_clk_i) begin
    st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register
  // data outputs read zero whenever their enables are low

  assign din_o = st_q.din;
  assign din_oe_o = st_q.din_oe;
  assign int_data_o = st_q.idata;
  assign int_data_oe_o = st_q.idata_oe;
  assign out_buffer_enable_n_o = st_q.out_en_n;
  assign in_buffer_enable_n_o = st_q.in_en_n;
  assign board_select_o = st_q.board_sel;
  assign io_cycle_active_o = st_q.io_act;
  assign bank_enable_n_o = st_q.bank_en_n;
  assign func_write_o = st_q.func_wr;
  assign block_sel_n_o = st_q.block_n;
  assign mem_ce_n_o = st_q.mem_ce_n;
  assign mem_addr_o = st_q.addr_buf;
  assign serial_one_select_n_o = st_q.ser1_n;
  assign serial_two_select_n_o = st_q.ser2_n;
  assign tape_select_n_o = st_q.tape_n;
  assign parallel_adapter_select_n_o = st_q.par_n;
  assign switch_reg_select_n_o = st_q.sw_n;

endmodule // bad_decode

// File: test/bad_decode_asserts.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// port-level checks; outputs all leave one state register, so most relations
// are same-cycle, and input causes are looked up 4 or 5 edges back
module bad_decode_asserts (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // cycle inputs
  input wire logic sinp_i,
  input wire logic sout_i,
  input wire logic jump_oe_i,
  // outputs watched
  input wire logic [bad_pkg::DATA_W-1:0] din_o,
  input wire logic din_oe_o,
  input wire logic int_data_oe_o,
  input wire logic out_buffer_enable_n_o,
  input wire logic in_buffer_enable_n_o,
  input wire logic board_select_o,
  input wire logic io_cycle_active_o,
  input wire logic func_write_o,
  input wire logic [bad_pkg::BLOCKS-1:0] block_sel_n_o,
  input wire logic [bad_pkg::NUM_MEM-1:0] mem_ce_n_o,
  input wire logic serial_one_select_n_o,
  input wire logic serial_two_select_n_o,
  input wire logic tape_select_n_o,
  input wire logic parallel_adapter_select_n_o,
  input wire logic switch_reg_select_n_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // port selects gathered, bit 0 serial one up to bit 4 switch register
  wire logic [4:0] psel_n;
  assign psel_n = {switch_reg_select_n_o, parallel_adapter_select_n_o,
                   tape_select_n_o, serial_two_select_n_o,
                   serial_one_select_n_o};
  // pin causes seen through the synchroniser delay
  sequence s_jump_seen;
    $past(jump_oe_i, 4) || $past(jump_oe_i, 5);
  endsequence
  sequence s_io_seen;
    $past(sinp_i | sout_i, 4) || $past(sinp_i | sout_i, 5);
  endsequence
  AST_OUT_DRIVES: assert property (
    !out_buffer_enable_n_o |-> din_oe_o)
    else $error("data-in not driven while out enable low");
  AST_OUT_GATE: assert property (
    !out_buffer_enable_n_o |-> (board_select_o or s_jump_seen))
    else $error("out enable without cause");
  AST_JUMP_OUT: assert property (
    !board_select_o && din_oe_o |-> s_jump_seen)
    else $error("drive without select or jump request");
  AST_IN_EN: assert property (
    in_buffer_enable_n_o == !int_data_oe_o)
    else $error("in enable and internal drive disagree");
  AST_FUNC_WR: assert property (
    func_write_o |-> board_select_o && !in_buffer_enable_n_o)
    else $error("stray write");
  AST_MEM_NO_IO: assert property (
    io_cycle_active_o |-> &mem_ce_n_o && &block_sel_n_o)
    else $error("memory during io");
  AST_IO_CAUSE: assert property (
    $rose(io_cycle_active_o) |-> s_io_seen)
    else $error("io active without strobe");
  AST_BLOCK_HOT: assert property (
    $onehot0(~block_sel_n_o))
    else $error("more than one block select");
  AST_SUB_BLOCK: assert property (
    !(&mem_ce_n_o) |-> !(&block_sel_n_o))
    else $error("chip enable outside any block");
  AST_PORT_HOT: assert property (
    !(&psel_n) |-> $onehot(~psel_n) && io_cycle_active_o)
    else $error("bad port select");
  AST_BOARD: assert property (
    !(&mem_ce_n_o) || !(&psel_n) |-> board_select_o)
    else $error("board select missing");
  AST_IDLE_DATA: assert property (
    !din_oe_o |-> din_o == 8'h00 && out_buffer_enable_n_o)
    else $error("data-in not released");
endmodule // bad_decode_asserts

bind bad_decode bad_decode_asserts u_asserts (.core_clk_i, .rst_n_i, .sinp_i,
  .sout_i, .jump_oe_i, .din_o, .din_oe_o, .int_data_oe_o,
  .out_buffer_enable_n_o, .in_buffer_enable_n_o, .board_select_o,
  .io_cycle_active_o, .func_write_o, .block_sel_n_o, .mem_ce_n_o,
  .serial_one_select_n_o, .serial_two_select_n_o, .tape_select_n_o,
  .parallel_adapter_select_n_o, .switch_reg_select_n_o);

// File: test/bad_cpu_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// backplane processor: one cycle kind at a time, changed at falling edges
module bad_cpu_model (
  // clock
  input wire logic core_clk_i,
  // backplane cycle
  output logic [bad_pkg::ADDR_W-1:0] addr_o = 20'h05000,
  output logic smemr_o = 1'b0,
  output logic sinp_o = 1'b0,
  output logic sout_o = 1'b0,
  output logic mwrite_o = 1'b0,
  output logic [bad_pkg::DATA_W-1:0] dout_o = 8'h00
);
  // kind: 0 idle, 1 memory read, 2 memory write, 3 input, 4 output
  task automatic cycle(input logic [19:0] a, input int k, input logic [7:0] d);
    @(negedge core_clk_i);
    addr_o = a;
    smemr_o = (k == 1);
    mwrite_o = (k == 2);
    sinp_o = (k == 3);
    sout_o = (k == 4);
    // undriven data-out shows the inverse so a stale value never matches
    dout_o = (k == 2 || k == 4) ? d : ~dout_o;
  endtask
endmodule // bad_cpu_model

// File: test/bus_address_decode_bench.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module bus_address_decode_bench;
  // stimulus and observed signals
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [19:0] addr_i;
  logic smemr_i, sinp_i, sout_i, mwrite_i, din_oe_o, int_data_oe_o;
  logic jump_oe_i = 1'b0;
  logic ext_addr_en_i = 1'b0;
  logic a19_match_i = 1'b1;
  logic [2:0] bank_cfg_i = 3'h5;
  logic [3:0] port_block_cfg_i = 4'h7;
  // memories: 2K F000, 1K F800, 1K FC00, 1K 0400, 1K 0000
  logic [34:0] mem_cfg_i = {7'h00, 7'h10, 7'h3F, 7'h2F, 7'h4F};
  logic [7:0] dout_i, din_o, int_data_o;
  logic [7:0] int_data_i = 8'hA5;
  logic out_buffer_enable_n_o, in_buffer_enable_n_o, board_select_o;
  logic io_cycle_active_o, bank_enable_n_o, func_write_o;
  logic [15:0] block_sel_n_o;
  logic [4:0] mem_ce_n_o;
  wire [4:0] ps;
  logic [11:0] mem_addr_o;
  logic [19:0] ta [6] = '{20'h0F123, 20'h0F900, 20'h0FD00, 20'h00500,
                          20'h00200, 20'h05ABC};
  logic [4:0] tc [6] = '{5'h1E, 5'h1D, 5'h1B, 5'h17, 5'h0F, 5'h1F};
  int err_count = 0;
  int checks = 0;

  bad_decode dut (.core_clk_i, .rst_n_i, .addr_i, .smemr_i, .sinp_i, .sout_i,
    .mwrite_i, .jump_oe_i, .dout_i, .din_o, .din_oe_o, .int_data_i,
    .int_data_o, .int_data_oe_o, .ext_addr_en_i, .a19_match_i, .bank_cfg_i,
    .port_block_cfg_i, .mem_cfg_i, .out_buffer_enable_n_o,
    .in_buffer_enable_n_o, .board_select_o, .io_cycle_active_o,
    .bank_enable_n_o, .func_write_o, .block_sel_n_o, .mem_ce_n_o, .mem_addr_o,
    .serial_one_select_n_o(ps[0]), .serial_two_select_n_o(ps[1]),
    .tape_select_n_o(ps[2]), .parallel_adapter_select_n_o(ps[3]),
    .switch_reg_select_n_o(ps[4]));
  bad_cpu_model cpu (.core_clk_i, .addr_o(addr_i), .smemr_o(smemr_i),
    .sinp_o(sinp_i), .sout_o(sout_i), .mwrite_o(mwrite_i), .dout_o(dout_i));

  ////////////////////////////////////////////////////////////////////////////
  // clock, watchdog well past the roughly 300 cycles of tests
  initial forever #25 core_clk_i = ~core_clk_i;
  initial begin
    #200000;
    err_count++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (exp !== got) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // six edges covers the 5 cycle pipeline; look at a falling edge
  task automatic settle;
    repeat (6) @(negedge core_clk_i);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // every port of the block, upper address bits point at our memory
  task automatic t_ports;
    logic [4:0] e;
    for (int p = 'h70; p <= 'h7F; p++) begin
      cpu.cycle(20'h0F000 | p, 3, 8'h00);
      settle();
      case (p[3:1])
        0: e = 5'h1E;
        1: e = 5'h1D;
        2: e = 5'h1B;
        3, 4: e = 5'h17;
        5: e = 5'h0F;
        default: e = 5'h1F;
      endcase
      chk("port selects", e, ps);
      chk("board select", e != 5'h1F, board_select_o);
      chk("out enable n", e == 5'h1F, out_buffer_enable_n_o);
      chk("data in", e != 5'h1F ? 8'hA5 : 8'h00, din_o);
      chk("mem ce in io", 5'h1F, mem_ce_n_o);
      chk("io active", 1'b1, io_cycle_active_o);
    end
    cpu.cycle(20'h00061, 3, 8'h00);
    settle();
    chk("other port block", 5'h1F, ps);
  endtask
  // memory reads over a table of hits and one miss
  task automatic t_mem;
    logic [15:0] eb;
    for (int i = 0; i < 6; i++) begin
      cpu.cycle(ta[i], 1, 8'h00);
      settle();
      // sized here so the inversion cannot spill into wider bits
      eb = ~(16'h0001 << ta[i][15:12]);
      chk("chip enables", tc[i], mem_ce_n_o);
      chk("block", eb, block_sel_n_o);
      chk("mem addr", ta[i][11:0], mem_addr_o);
      chk("board select", tc[i] != 5'h1F, board_select_o);
      chk("out enable n", tc[i] == 5'h1F, out_buffer_enable_n_o);
      chk("io idle", 1'b0, io_cycle_active_o);
    end
  endtask
  task automatic wr(input logic [19:0] a, input int k, input logic [7:0] d,
                    input logic fw);
    cpu.cycle(a, k, d);
    settle();
    chk("in enable n", 1'b0, in_buffer_enable_n_o);
    chk("internal data", d, int_data_o);
    chk("internal drive", 1'b1, int_data_oe_o);
    chk("func write", fw, func_write_o);
    chk("out enable n", 1'b1, out_buffer_enable_n_o);
  endtask
  // writes to our memory, elsewhere, our port and an inhibited port
  task automatic t_write;
    wr(20'h0F900, 2, 8'h5A, 1'b1);
    chk("chip enables", 5'h1D, mem_ce_n_o);
    wr(20'h05000, 2, 8'hC3, 1'b0);
    wr(20'h0F072, 4, 8'h11, 1'b1);
    chk("port selects", 5'h1D, ps);
    chk("blocks in io", 16'hFFFF, block_sel_n_o);
    wr(20'h0F07C, 4, 8'h22, 1'b0);
  endtask
  task automatic bank(input logic m, input logic [19:0] a, input logic hit);
    @(negedge core_clk_i);
    a19_match_i = m;
    cpu.cycle(a, 1, 8'h00);
    settle();
    chk("bank enable n", !hit, bank_enable_n_o);
    chk("chip enables", hit ? 5'h1E : 5'h1F, mem_ce_n_o);
  endtask
  // extended addressing, bank 5 strapped
  task automatic t_bank;
    @(negedge core_clk_i);
    ext_addr_en_i = 1'b1;
    bank(1'b1, 20'hDF000, 1'b1);
    bank(1'b1, 20'h5F000, 1'b0);
    bank(1'b1, 20'hCF000, 1'b0);
    bank(1'b0, 20'h5F000, 1'b1);
    @(negedge core_clk_i);
    ext_addr_en_i = 1'b0;
  endtask
  // jump request alone drives data-in, then lets go
  task automatic t_jump;
    cpu.cycle(20'h05000, 0, 8'h00);
    @(negedge core_clk_i);
    int_data_i = 8'h3C;
    jump_oe_i = 1'b1;
    settle();
    chk("jump out enable n", 1'b0, out_buffer_enable_n_o);
    chk("jump data", 8'h3C, din_o);
    chk("jump board select", 1'b0, board_select_o);
    jump_oe_i = 1'b0;
    settle();
    chk("released drive", 1'b0, din_oe_o);
    chk("released data", 8'h00, din_o);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reset, idle check, then the scenarios
  initial begin
    repeat (20) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    settle();
    chk("idle drive", 1'b0, din_oe_o);
    chk("idle chip enables", 5'h1F, mem_ce_n_o);
    chk("idle internal drive", 1'b0, int_data_oe_o);
    t_ports();
    t_mem();
    t_write();
    t_bank();
    t_jump();
    complete_run();
  end
endmodule // bus_address_decode_bench
